// ==== rtl/eeprom_pkg.sv ====
// Types shared by the serial EEPROM command engine.
// Assumes nothing beyond a SystemVerilog compiler.
package eeprom_pkg;
	typedef enum logic [2:0] {
		ST_IDLE, ST_HDR, ST_DATA, ST_ARMED, ST_READ, ST_SKIP
	} state_e;
	typedef logic [15:0] word_t;
	typedef struct packed {
		logic        mass;
		logic        clr;
		logic        x16;
		logic [9:0]  addr;
		word_t       data;
	} cmd_s;
endpackage : eeprom_pkg

// ==== rtl/eeprom_regs.svh ====
// Opcodes, frame lengths, fill values and timing for the EEPROM engine.
// Assumes a 10 MHz core clock; included by bare name.
`ifndef EEPROM_REGS_SVH
`define EEPROM_REGS_SVH
`define OP_SPECIAL     2'h0
`define OP_WRITE       2'h1
`define OP_READ        2'h2
`define OP_ERASE       2'h3
`define SUB_LOCK       2'h0
`define SUB_FILL_ALL   2'h1
`define SUB_CLEAR_ALL  2'h2
`define SUB_UNLOCK     2'h3
`define HDR_LEN_X16    5'h0C
`define HDR_LEN_X8     5'h0D
`define DAT_LEN_X16    5'h10
`define DAT_LEN_X8     5'h08
`define ERASED_BYTE    8'hFF
`define STEP_X16       10'h002
`define STEP_X8        10'h001
`define LAST_BYTE      10'h3FF
`define BUF_DEPTH      2'h2
`define CLK_PERIOD_NS  100
`define NS_PER_MS      1000000
`define PROG_TIME_MS   5
`endif

// ==== rtl/serial_eeprom_command_engine.sv ====
// Serial EEPROM command engine with 8192-bit array and self-timed programming.
// Assumes the serial pins are asynchronous to core_clk, which runs much faster.
`timescale 1ns/1ps
`default_nettype none
`include "eeprom_regs.svh"

// How it works
// - Frame is 13 bits in 16-bit mode, 14 bits in 8-bit mode.
// - Data input bits are taken on each serial clock rising edge.
// - Output floats except for read data or ready/busy status.
// - Select after programming shows low while busy, high when ready.
// - A one shifted in during status floats output at clock fall.
// - Frame: start one, opcode, 10 or 11 address bits, optional data.
// - Top address bit is sent but ignored.
// - Read drives output, sends a zero, then word MSB first.
// - Read output bits change after serial clock rising edges.
// - Held select keeps reading next addresses, wrapping to zero.
// - Only the first read word has the leading zero.
// - Select fall after write starts self-timed store over the old word.
// - Write needs no prior erase of the word.
// - Erase clears the addressed word to all ones.
// - Starts locked; unlock enables until lock or power loss.
// - Locked device ignores programming commands but still reads.
// - Clear-all sets every array bit to one.
// - Fill-all writes the data word to every location.
// - Select must fall before next clock rise or nothing programs.
// - Power-on reset leaves the device locked, read-only.
// - Word size pin high selects 16-bit words, low 8-bit.
module serial_eeprom_command_engine #(
	parameter int unsigned PROG_CYC = `PROG_TIME_MS * `NS_PER_MS / `CLK_PERIOD_NS
) (
	input  wire logic core_clk,
	input  wire logic rst_n,
	input  wire logic device_select,
	input  wire logic serial_clock_in,
	input  wire logic serial_data_in,
	input  wire logic word_size_select,
	output logic      serial_data_out,
	output logic      serial_data_oe,
	output logic      prog_busy,
	output logic      write_enabled
);
	logic [2:0]              sk_q;
	logic [2:0]              cs_q;
	logic [1:0]              di_q;
	logic [1:0]              ws_q;
	eeprom_pkg::state_e      state_reg;
	logic [4:0]              cnt_reg;
	logic [12:0]             hdr_reg;
	eeprom_pkg::word_t       dat_reg;
	eeprom_pkg::cmd_s        cmd_reg;
	eeprom_pkg::cmd_s        prog_reg;
	logic                    wen_reg;
	logic                    busy_reg;
	logic                    walk_reg;
	logic [31:0]             tmr_reg;
	logic [9:0]              idx_reg;
	logic                    pend_reg;
	logic                    stat_reg;
	logic                    rel_reg;
	logic [7:0]              mem [0:1023];
	eeprom_pkg::word_t       buf_reg [0:1];
	logic                    wp_reg;
	logic                    rp_reg;
	logic [1:0]              fcnt_reg;
	logic [9:0]              rd_addr_reg;
	logic                    do_reg;
	logic                    oe_reg;
	eeprom_pkg::word_t       sh_reg;
	logic [4:0]              left_reg;

	// Pin synchronisers, two flops before use
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			sk_q <= 3'h0;
			cs_q <= 3'h0;
			di_q <= 2'h0;
			ws_q <= 2'h3;
		end else begin
			sk_q <= {sk_q[1:0], serial_clock_in};
			cs_q <= {cs_q[1:0], device_select};
			di_q <= {di_q[0], serial_data_in};
			ws_q <= {ws_q[0], word_size_select};
		end
	end

	logic              cs_on;
	logic              sk_rise;
	logic              sk_fall;
	logic              cs_fall;
	logic              cs_rise;
	logic              di;
	logic              x16;
	logic [12:0]       hdr_next;
	eeprom_pkg::word_t dat_next;
	logic [1:0]        op;
	logic [1:0]        sub;
	logic [9:0]        baddr;
	logic              hdr_done;
	logic              dat_done;
	logic              rd_start;
	logic              unlock_hit;
	logic              start;
	assign cs_on    = cs_q[1];
	assign sk_rise  = sk_q[1] & ~sk_q[2] & cs_on;
	assign sk_fall  = ~sk_q[1] & sk_q[2];
	assign cs_fall  = ~cs_q[1] & cs_q[2];
	assign cs_rise  = cs_q[1] & ~cs_q[2];
	assign di       = di_q[1];
	assign x16      = ws_q[1];
	assign hdr_next = {hdr_reg[11:0], di};
	assign dat_next = {dat_reg[14:0], di};
	assign op       = x16 ? hdr_next[11:10] : hdr_next[12:11];
	assign sub      = x16 ? hdr_next[9:8] : hdr_next[10:9];
	assign baddr    = x16 ? {hdr_next[8:0], 1'b0} : hdr_next[9:0];
	assign hdr_done = sk_rise && state_reg == eeprom_pkg::ST_HDR
		&& cnt_reg == (x16 ? `HDR_LEN_X16 : `HDR_LEN_X8) - 5'h01;
	assign dat_done = sk_rise && state_reg == eeprom_pkg::ST_DATA
		&& cnt_reg == (x16 ? `DAT_LEN_X16 : `DAT_LEN_X8) - 5'h01;
	assign rd_start = hdr_done && op == `OP_READ;
	assign unlock_hit = hdr_done && op == `OP_SPECIAL && sub == `SUB_UNLOCK;
	assign start    = cs_fall && state_reg == eeprom_pkg::ST_ARMED;

	// Frame decoder
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			state_reg <= eeprom_pkg::ST_IDLE;
			cnt_reg   <= 5'h00;
			hdr_reg   <= 13'h0000;
			dat_reg   <= 16'h0000;
			cmd_reg   <= '0;
		end else if (!cs_on) begin
			state_reg <= eeprom_pkg::ST_IDLE;
			cnt_reg   <= 5'h00;
		end else if (sk_rise) begin
			case (state_reg)
				eeprom_pkg::ST_IDLE: begin
					if (di && !busy_reg) begin
						state_reg <= eeprom_pkg::ST_HDR;
						cnt_reg   <= 5'h00;
					end
				end
				eeprom_pkg::ST_HDR: begin
					hdr_reg <= hdr_next;
					cnt_reg <= cnt_reg + 5'h01;
					if (hdr_done) begin
						cnt_reg      <= 5'h00;
						cmd_reg.addr <= baddr;
						cmd_reg.x16  <= x16;
						cmd_reg.clr  <= op == `OP_ERASE
							|| (op == `OP_SPECIAL && sub == `SUB_CLEAR_ALL);
						cmd_reg.mass <= op == `OP_SPECIAL;
						case (op)
							`OP_READ: state_reg <= eeprom_pkg::ST_READ;
							`OP_WRITE: state_reg <= eeprom_pkg::ST_DATA;
							`OP_ERASE: state_reg <= wen_reg ? eeprom_pkg::ST_ARMED
								: eeprom_pkg::ST_SKIP;
							default: begin
								if (sub == `SUB_FILL_ALL)
									state_reg <= eeprom_pkg::ST_DATA;
								else if (sub == `SUB_CLEAR_ALL && wen_reg)
									state_reg <= eeprom_pkg::ST_ARMED;
								else
									state_reg <= eeprom_pkg::ST_SKIP;
							end
						endcase
					end
				end
				eeprom_pkg::ST_DATA: begin
					dat_reg <= dat_next;
					cnt_reg <= cnt_reg + 5'h01;
					if (dat_done) begin
						cmd_reg.data <= dat_next;
						state_reg    <= wen_reg ? eeprom_pkg::ST_ARMED
							: eeprom_pkg::ST_SKIP;
					end
				end
				eeprom_pkg::ST_ARMED: state_reg <= eeprom_pkg::ST_SKIP;
				default: state_reg <= state_reg;
			endcase
		end
	end

	// Write-enable latch, locked from power-on
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n)
			wen_reg <= 1'b0;
		else if (unlock_hit)
			wen_reg <= 1'b1;
		else if (hdr_done && op == `OP_SPECIAL && sub == `SUB_LOCK)
			wen_reg <= 1'b0;
	end

	// Self-timed programming cycle
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			busy_reg <= 1'b0;
			walk_reg <= 1'b0;
			tmr_reg  <= 32'h0;
			idx_reg  <= 10'h000;
			prog_reg <= '0;
		end else if (start) begin
			busy_reg <= 1'b1;
			walk_reg <= 1'b1;
			tmr_reg  <= 32'h0;
			idx_reg  <= 10'h000;
			prog_reg <= cmd_reg;
		end else if (busy_reg) begin
			tmr_reg <= tmr_reg + 32'h1;
			if (walk_reg) begin
				idx_reg <= idx_reg + 10'h001;
				if (idx_reg == `LAST_BYTE)
					walk_reg <= 1'b0;
			end
			if (tmr_reg == PROG_CYC - 32'h1)
				busy_reg <= 1'b0;
		end
	end

	logic       hit;
	logic [7:0] wbyte;
	assign hit = prog_reg.mass || idx_reg == prog_reg.addr
		|| (prog_reg.x16 && idx_reg == {prog_reg.addr[9:1], 1'b1});
	assign wbyte = prog_reg.clr ? `ERASED_BYTE
		: (prog_reg.x16 && !idx_reg[0]) ? prog_reg.data[15:8] : prog_reg.data[7:0];

	// Array store, overwrite without prior clear
	always_ff @(posedge core_clk) begin
		if (busy_reg && walk_reg && hit)
			mem[idx_reg] <= wbyte;
	end

	// Status polling
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			pend_reg <= 1'b0;
			stat_reg <= 1'b0;
			rel_reg  <= 1'b0;
		end else begin
			if (start)
				pend_reg <= 1'b1;
			else if (rel_reg && sk_fall)
				pend_reg <= 1'b0;
			if (!cs_on || (rel_reg && sk_fall)) begin
				stat_reg <= 1'b0;
				rel_reg  <= 1'b0;
			end else begin
				if (cs_rise && pend_reg)
					stat_reg <= 1'b1;
				if (stat_reg && sk_rise && di)
					rel_reg <= 1'b1;
			end
		end
	end

	// Two-entry read buffer
	logic              push;
	logic              pop;
	logic              in_ready;
	logic              out_valid;
	eeprom_pkg::word_t rd_word;
	eeprom_pkg::word_t head;
	assign in_ready  = fcnt_reg != `BUF_DEPTH;
	assign out_valid = fcnt_reg != 2'h0;
	assign push = state_reg == eeprom_pkg::ST_READ && in_ready && !rd_start && cs_on;
	assign pop  = sk_rise && state_reg == eeprom_pkg::ST_READ && left_reg == 5'h00
		&& out_valid;
	assign rd_word = x16 ? {mem[rd_addr_reg], mem[rd_addr_reg | 10'h001]}
		: {mem[rd_addr_reg], 8'h00};
	assign head = buf_reg[rp_reg];

	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			wp_reg      <= 1'b0;
			rp_reg      <= 1'b0;
			fcnt_reg    <= 2'h0;
			rd_addr_reg <= 10'h000;
			buf_reg[0]  <= 16'h0000;
			buf_reg[1]  <= 16'h0000;
		end else if (rd_start || !cs_on) begin
			wp_reg      <= 1'b0;
			rp_reg      <= 1'b0;
			fcnt_reg    <= 2'h0;
			rd_addr_reg <= baddr;
		end else begin
			if (push) begin
				buf_reg[wp_reg] <= rd_word;
				wp_reg          <= ~wp_reg;
				rd_addr_reg     <= rd_addr_reg + (x16 ? `STEP_X16 : `STEP_X8);
			end
			if (pop)
				rp_reg <= ~rp_reg;
			fcnt_reg <= fcnt_reg + {1'b0, push} - {1'b0, pop};
		end
	end

	// Output driver
	always_ff @(posedge core_clk or negedge rst_n) begin
		if (!rst_n) begin
			do_reg   <= 1'b0;
			oe_reg   <= 1'b0;
			sh_reg   <= 16'h0000;
			left_reg <= 5'h00;
		end else if (!cs_on) begin
			oe_reg   <= 1'b0;
			do_reg   <= 1'b0;
			left_reg <= 5'h00;
		end else if (rd_start) begin
			oe_reg   <= 1'b1;
			do_reg   <= 1'b0;
			left_reg <= 5'h00;
		end else if (state_reg == eeprom_pkg::ST_READ && sk_rise) begin
			if (left_reg == 5'h00) begin
				do_reg   <= head[15];
				sh_reg   <= {head[14:0], 1'b0};
				left_reg <= (x16 ? `DAT_LEN_X16 : `DAT_LEN_X8) - 5'h01;
			end else begin
				do_reg   <= sh_reg[15];
				sh_reg   <= {sh_reg[14:0], 1'b0};
				left_reg <= left_reg - 5'h01;
			end
		end else if (stat_reg && rel_reg && sk_fall) begin
			oe_reg <= 1'b0;
		end else if (stat_reg) begin
			oe_reg <= 1'b1;
			do_reg <= ~busy_reg;
		end
	end

	assign serial_data_out = do_reg;
	assign serial_data_oe  = oe_reg;
	assign prog_busy       = busy_reg;
	assign write_enabled   = wen_reg;

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!rst_n);

	sequence s_prog_start;
		cs_fall && state_reg == eeprom_pkg::ST_ARMED;
	endsequence
	sequence s_busy_hold;
		busy_reg [*8];
	endsequence

	property p_prog_runs;
		s_prog_start |=> s_busy_hold;
	endproperty
	a_prog_runs: assert property (p_prog_runs) else $error("no program cycle");

	property p_late_drop;
		cs_fall && state_reg != eeprom_pkg::ST_ARMED && !busy_reg |=> !busy_reg;
	endproperty
	a_late_drop: assert property (p_late_drop) else $error("stray program");

	property p_oe_cause;
		oe_reg |-> state_reg == eeprom_pkg::ST_READ || stat_reg;
	endproperty
	a_oe_cause: assert property (p_oe_cause) else $error("output driven idle");

	property p_dummy_zero;
		rd_start |=> oe_reg && !do_reg;
	endproperty
	a_dummy_zero: assert property (p_dummy_zero) else $error("no leading zero");

	property p_status_level;
		stat_reg && $past(stat_reg) && oe_reg |-> do_reg == !$past(busy_reg);
	endproperty
	a_status_level: assert property (p_status_level) else $error("bad status");

	property p_release;
		stat_reg && rel_reg && sk_fall |=> !oe_reg;
	endproperty
	a_release: assert property (p_release) else $error("status not released");

	property p_unlock_only;
		$rose(wen_reg) |-> $past(unlock_hit);
	endproperty
	a_unlock_only: assert property (p_unlock_only) else $error("enabled without unlock");

	property p_locked_armless;
		state_reg == eeprom_pkg::ST_ARMED |-> wen_reg;
	endproperty
	a_locked_armless: assert property (p_locked_armless) else $error("locked armed");

	property p_read_steady;
		state_reg == eeprom_pkg::ST_READ && !sk_rise && cs_on |=> $stable(do_reg);
	endproperty
	a_read_steady: assert property (p_read_steady) else $error("read bit moved");

	property p_wrap;
		push && rd_addr_reg == `LAST_BYTE |=> rd_addr_reg == 10'h000 || !cs_on;
	endproperty
	a_wrap: assert property (p_wrap) else $error("no address wrap");
endmodule : serial_eeprom_command_engine
`default_nettype wire

// ==== tb/eeprom_host_model.sv ====
// Host model: drives select, serial clock and data in.
// Assumes the bench samples the data line between rise_bit and fall.
`timescale 1ns/1ps
`default_nettype none
module eeprom_host_model (
	input  wire logic core_clk,
	output logic      sel,
	output logic      sclk,
	output logic      sdi
);
	initial begin
		sel = 1'b0;
		sclk = 1'b0;
		sdi = 1'b0;
	end
	task automatic wait_clk(input int n);
		repeat (n) @(negedge core_clk);
	endtask : wait_clk
	// Data held six clocks either side of the rise; clock toggles from low
	task automatic rise_bit(input logic d);
		sdi = d;
		wait_clk(6);
		sclk = ~sclk;
		wait_clk(6);
	endtask : rise_bit
	// Clock back low
	task automatic fall;
		sclk = ~sclk;
	endtask : fall
	task automatic put_bit(input logic d);
		rise_bit(d);
		fall();
	endtask : put_bit
	// Select toggles; open and close always come in pairs
	task automatic open_frame;
		sel = ~sel;
		wait_clk(6);
	endtask : open_frame
	// Start bit, opcode, address, data, MSB first
	task automatic send(input logic [31:0] v, input int n);
		for (int i = n - 1; i >= 0; i--) put_bit(v[i]);
	endtask : send
	// Drop while clock low, inverted data line, long low time
	task automatic close_frame;
		sel = ~sel;
		sdi = ~sdi;
		wait_clk(8);
	endtask : close_frame
endmodule : eeprom_host_model
`default_nettype wire

// ==== tb/tb_top.sv ====
// Testbench for the serial EEPROM command engine.
// Assumes eeprom_host_model drives the serial pins.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	localparam int unsigned PROG_CYC = 1100;
	logic        core_clk;
	logic        rst_n;
	logic        word_size_select;
	wire logic   device_select;
	wire logic   serial_clock_in;
	wire logic   serial_data_in;
	logic        strobe;
	logic        serial_data_out;
	logic        serial_data_oe;
	logic        prog_busy;
	logic        write_enabled;
	wire logic   data_line;
	logic        exp_q[$];
	int          err_count;
	int          tests_run;
	int          seed;
	logic [15:0] d0, d1, d2, d3;

	assign data_line = serial_data_oe ? serial_data_out : 1'bz;

	serial_eeprom_command_engine #(.PROG_CYC(PROG_CYC)) dut (
		.core_clk        (core_clk),
		.rst_n           (rst_n),
		.device_select   (device_select),
		.serial_clock_in (serial_clock_in),
		.serial_data_in  (serial_data_in),
		.word_size_select(word_size_select),
		.serial_data_out (serial_data_out),
		.serial_data_oe  (serial_data_oe),
		.prog_busy       (prog_busy),
		.write_enabled   (write_enabled)
	);
	eeprom_host_model host (
		.core_clk(core_clk),
		.sel     (device_select),
		.sclk    (serial_clock_in),
		.sdi     (serial_data_in)
	);

	task automatic check(input string name, input logic [15:0] exp, input logic [15:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("ERROR %s expected %h seen %h", name, exp, got);
		end
	endtask : check
	task automatic summarize;
		$display("Checks %0d, errors %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask : summarize
	task automatic timed_out(input string name);
		check(name, 16'h0001, 16'h0000);
		summarize();
	endtask : timed_out
	// Oldest note against the line at each sample
	always @(posedge core_clk) begin
		if (strobe === 1'b1) begin
			if (exp_q.size() == 0) check("sample without note", 16'h0000, 16'h0001);
			else check("data line", {15'h0000, exp_q.pop_front()}, {15'h0000, data_line});
		end
	end
	// Asks the watcher to sample the line
	task automatic sample;
		strobe = 1'b1;
		host.wait_clk(1);
		strobe = 1'b0;
	endtask : sample
	task automatic expect_bit(input logic b);
		exp_q.push_back(b);
		sample();
	endtask : expect_bit
	task automatic frame(input logic [31:0] v, input int n);
		host.open_frame();
		host.send(v, n);
		host.close_frame();
	endtask : frame
	task automatic refused(input logic [31:0] v, input int n);
		frame(v, n);
		host.wait_clk(20);
		check("prog_busy", 16'h0000, {15'h0000, prog_busy});
	endtask : refused
	// Frame, then status poll until ready, then release
	task automatic prog(input logic [31:0] v, input int n);
		int cnt;
		frame(v, n);
		cnt = 0;
		while (prog_busy !== 1'b1) begin
			cnt++;
			if (cnt > 20) timed_out("busy start");
			host.wait_clk(1);
		end
		host.open_frame();
		expect_bit(1'b0);
		cnt = 0;
		while (prog_busy !== 1'b0) begin
			cnt++;
			if (cnt > PROG_CYC) timed_out("busy end");
			host.wait_clk(1);
		end
		check("busy length", 16'h0001, {15'h0000, cnt > PROG_CYC - 30});
		host.wait_clk(8);
		expect_bit(1'b1);
		host.put_bit(1'b1);
		host.wait_clk(8);
		expect_bit(1'bz);
		host.close_frame();
	endtask : prog
	task automatic rd(input logic [31:0] hdr, input int n, input logic [31:0] dat, input int nb);
		host.open_frame();
		host.send(hdr >> 1, n - 1);
		exp_q.push_back(1'b0);
		host.rise_bit(hdr[0]);
		sample();
		host.fall();
		for (int i = nb - 1; i >= 0; i--) begin
			exp_q.push_back(dat[i]);
			host.rise_bit(1'b0);
			sample();
			host.fall();
		end
		host.close_frame();
		expect_bit(1'bz);
	endtask : rd

	initial begin
		core_clk = 1'b0;
		forever #50 core_clk = ~core_clk;
	end
	initial begin
		rst_n = 1'b0;
		strobe = 1'b0;
		word_size_select = 1'b1;
		err_count = 0;
		tests_run = 0;
		seed = 32'h8C9981AD;
		d0 = 16'($random(seed));
		d1 = 16'($random(seed));
		d2 = 16'($random(seed));
		d3 = 16'($random(seed));
		repeat (5) @(posedge core_clk);
		@(negedge core_clk);
		rst_n = 1'b1;
		host.wait_clk(10);
		check("write_enabled", 16'h0000, {15'h0000, write_enabled});
		check("serial_data_oe", 16'h0000, {15'h0000, serial_data_oe});
		refused({3'b101, 10'h005, d0}, 29);
		frame({3'b100, 10'h300}, 13);
		check("write_enabled", 16'h0001, {15'h0000, write_enabled});
		prog({3'b100, 10'h200}, 13);
		rd({3'b110, 10'h010}, 13, 32'h0000FFFF, 16);
		prog({3'b101, 10'h200, d0}, 29);
		rd({3'b110, 10'h000}, 13, {16'h0000, d0}, 16);
		prog({3'b101, 10'h000, d1}, 29);
		prog({3'b101, 10'h1FF, d2}, 29);
		rd({3'b110, 10'h1FF}, 13, {d2, d1}, 32);
		prog({3'b111, 10'h1FF}, 13);
		rd({3'b110, 10'h3FF}, 13, 32'h0000FFFF, 16);
		refused({3'b101, 10'h004, d0, 1'b0}, 30);
		prog({3'b100, 10'h100, d3}, 29);
		rd({3'b110, 10'h0AB}, 13, {16'h0000, d3}, 16);
		word_size_select = 1'b0;
		rd({3'b110, 11'h7FF}, 14, {24'h000000, d3[7:0]}, 8);
		rd({3'b110, 11'h002}, 14, {24'h000000, d3[15:8]}, 8);
		word_size_select = 1'b1;
		frame({3'b100, 10'h000}, 13);
		check("write_enabled", 16'h0000, {15'h0000, write_enabled});
		refused({3'b111, 10'h0AB}, 13);
		rd({3'b110, 10'h0AB}, 13, {16'h0000, d3}, 16);
		frame({3'b100, 10'h300}, 13);
		check("write_enabled", 16'h0001, {15'h0000, write_enabled});
		rst_n = 1'b0;
		host.wait_clk(5);
		rst_n = 1'b1;
		host.wait_clk(10);
		check("write_enabled", 16'h0000, {15'h0000, write_enabled});
		check("serial_data_oe", 16'h0000, {15'h0000, serial_data_oe});
		rd({3'b110, 10'h0AB}, 13, {16'h0000, d3}, 16);
		host.wait_clk(20);
		check("notes left", 16'h0000, 16'(exp_q.size()));
		summarize();
	end
endmodule : tb_top
`default_nettype wire
